// >>> logic/mbm_pkg.sv
// Purpose: constants and types of the memory bank mapper
// Assumes: 8-bit data space, 12-bit program counter, 100 MHz mclk
// Notes:   shared by the mapper and its bench
package mbm_pkg;
    // =========================================================
    // data space decode
    localparam logic [7:0] DWIN_LO     = 8'h00;
    localparam logic [7:0] DWIN_HI     = 8'h3F;
    localparam logic [7:0] DROM_LO     = 8'h40;
    localparam logic [7:0] DROM_HI     = 8'h7F;
    localparam logic [7:0] DRAM_LO     = 8'h80;
    localparam logic [7:0] DRAM_HI     = 8'hBF;
    localparam logic [7:0] ADR_DWIN    = 8'hC9;
    localparam logic [7:0] ADR_PAGE    = 8'hCA;
    localparam logic [7:0] ADR_BANK    = 8'hE8;
    localparam logic [7:0] ADR_EECTL   = 8'hEA;
    localparam int         WIN_BITS    = 6;
    // =========================================================
    // bank select one-hot codes
    localparam logic [7:0] BANK_EE0    = 8'h01;
    localparam logic [7:0] BANK_EE1    = 8'h02;
    localparam logic [7:0] BANK_RAM2   = 8'h04;
    localparam logic [7:0] BANK_RAM3   = 8'h08;
    localparam logic [7:0] BANK_RAM4   = 8'h10;
    localparam logic [7:0] BANK_OSD5   = 8'h20;
    localparam logic [7:0] BANK_OSD6   = 8'h40;
    // =========================================================
    // eeprom control bit positions
    localparam int         EC_UNLOCK   = 0;
    localparam int         EC_BUSY     = 1;
    localparam int         EC_ARM      = 2;
    localparam int         EC_GO       = 3;
    localparam int         EC_SLEEP    = 6;
    localparam logic [7:0] EECTL_RST   = 8'h00;
    localparam logic [1:0] STATIC_PAGE = 2'b01;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int         ROW_BYTES   = 8;
    // =========================================================
    // timing
    localparam int         CLK_MHZ     = 100;
    localparam int         EE_WRITE_US = 5000;
    localparam int         EE_WRITE_CYC = EE_WRITE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        MBM_IDLE = 2'b00,
        MBM_BYTE = 2'b01,
        MBM_ROW  = 2'b10
    } mbm_ee_st_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mbm_dreq_t;
endpackage : mbm_pkg

// >>> logic/mbm_mapper.sv
// Purpose: program/data space mapping and eeprom control
// Assumes: core issues one data access per cycle, reads answered next edge
// Notes:   page/window/bank registers are write only and not reset
`timescale 1ns/1ps
// Function
// - low 2K fetch uses selected ROM page
// - top bit set fetches static page 1
// - page select write only, undefined reset
// - data 40H-7FH reads ROM window bytes
// - ROM address is window bits, low six
// - window register at C9H, write only
// - 80H-BFH always reach fixed RAM
// - 00H-3FH banked by register E8H
// - bank values decode one-hot to pages
// - eeprom read like data, 64-byte modules
// - eeprom write about 5ms, busy flag
// - byte writes and eight-byte row writes
// - control at EAH, sleep disables eeprom; a row go is still accepted in sleep
// - go bit starts row, cleared at end
// - armed row writes fill volatile latches
// - arm cleared at end; unarm aborts
// - unloaded row bytes end erased (FFH)
// - busy set on write, accesses aborted
// - writes need unlock bit, else ignored
// - control register resets to 00H
// - go accepted only with unlock and arm
module mbm_mapper #(
    parameter int WRITE_CYC = mbm_pkg::EE_WRITE_CYC
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [11:0]      pc,
    input  wire mbm_pkg::mbm_dreq_t dreq,
    input  wire logic [7:0]       rom_data,
    output logic [12:0]           rom_fetch_addr,
    output logic [12:0]           rom_data_addr,
    output logic [7:0]            rdata,
    output logic                  eeprom_power_down
);
    localparam int CW      = $clog2(WRITE_CYC + 1);
    localparam int ROW_SEL = 4;

    // page_ok only tells the fetch check that the page is no longer unknown
    typedef struct packed {
        logic [1:0]             page;
        logic                   page_ok;
        logic [6:0]             win;
        logic [7:0]             bank;
        logic [7:0]             ctl;
        mbm_pkg::mbm_ee_st_t    st;
        logic [CW-1:0]          cnt;
        logic [6:0]             byte_addr;
        logic [7:0]             byte_data;
        logic [ROW_SEL-1:0]     row_sel;
        logic                   row_held;
        logic [7:0][7:0]        lat;
        logic [7:0]             lmask;
        logic [12:0]            fetch;
        logic [12:0]            daddr;
        logic [7:0]             rd;
        logic                   rd_rom;
    } mbm_state_t;

    mbm_state_t   cur_ff;
    mbm_state_t   nxt_s;
    logic [7:0]   fix_ram [0:63];
    // five 64-byte pages: ram 2..4, then display 5..6
    logic [7:0]   ban_ram [0:319];
    logic [7:0]   eeprom  [0:127];
    logic [7:0]   ram_rd;
    logic [7:0]   eeprom_rd;
    logic         in_win;
    logic         in_fix;
    logic         in_rom;
    logic         ee_hit;
    logic [6:0]   ee_idx;
    logic [8:0]   bank_idx;
    logic         bank_found;
    logic         bank_ram;
    logic         busy;
    logic         ee_wr;
    logic         row_fin;

    // =========================================================
    // decode
    always_comb begin
        in_win  = dreq.addr <= mbm_pkg::DWIN_HI;
        in_rom  = dreq.addr >= mbm_pkg::DROM_LO && dreq.addr <= mbm_pkg::DROM_HI;
        in_fix  = dreq.addr >= mbm_pkg::DRAM_LO && dreq.addr <= mbm_pkg::DRAM_HI;
        busy    = cur_ff.ctl[mbm_pkg::EC_BUSY];
        // one-hot bank decode; multiple bits resolve to lowest
        ee_hit  = in_win && (cur_ff.bank[0] || cur_ff.bank[1]);
        ee_idx  = {cur_ff.bank[1] & ~cur_ff.bank[0], dreq.addr[5:0]};
        bank_ram = in_win && !ee_hit && (cur_ff.bank[6:2] != 5'h00);
        bank_idx   = 9'h000;
        bank_found = 1'b0;
        for (int i = 2; i <= 6; i++) begin
            if (cur_ff.bank[i] && !bank_found) begin
                // pages sit back to back, 64 bytes each, so no page aliases another
                bank_idx   = {3'(i - 2), dreq.addr[5:0]};
                bank_found = 1'b1;
            end
        end
        // write into eeprom window, refused while busy/sleep/locked
        ee_wr = dreq.valid && dreq.write && ee_hit && !busy
            && !cur_ff.ctl[mbm_pkg::EC_SLEEP] && cur_ff.ctl[mbm_pkg::EC_UNLOCK];
        row_fin = cur_ff.st == mbm_pkg::MBM_ROW && cur_ff.cnt == CW'(0);
    end

    // =========================================================
    // next state
    always_comb begin
        nxt_s = cur_ff;
        nxt_s.rd_rom = 1'b0;
        // fetch mapping
        nxt_s.fetch = pc[11] ? {mbm_pkg::STATIC_PAGE, pc[10:0]} : {cur_ff.page, pc[10:0]};
        // rom window address
        nxt_s.daddr = {cur_ff.win, dreq.addr[mbm_pkg::WIN_BITS-1:0]};
        if (dreq.valid && !dreq.write) begin
            if (in_rom) nxt_s.rd_rom = 1'b1;
            else if (in_fix) nxt_s.rd = ram_rd;
            else if (ee_hit) nxt_s.rd = (busy || cur_ff.ctl[mbm_pkg::EC_SLEEP])
                                        ? mbm_pkg::ERASED_BYTE : eeprom_rd;
            else if (bank_ram) nxt_s.rd = ram_rd;
            else if (dreq.addr == mbm_pkg::ADR_EECTL)
                nxt_s.rd = {6'h00, busy, 1'b0} & 8'h02;
            else nxt_s.rd = 8'h00;
        end
        if (dreq.valid && dreq.write) begin
            unique case (dreq.addr)
                mbm_pkg::ADR_PAGE: begin
                    nxt_s.page    = dreq.wdata[1:0];
                    nxt_s.page_ok = 1'b1;
                end
                mbm_pkg::ADR_DWIN: nxt_s.win  = dreq.wdata[6:0];
                mbm_pkg::ADR_BANK: nxt_s.bank = {1'b0, dreq.wdata[6:0]};
                mbm_pkg::ADR_EECTL: begin
                    // control frozen while busy
                    if (!busy) begin
                        nxt_s.ctl[mbm_pkg::EC_UNLOCK] = dreq.wdata[mbm_pkg::EC_UNLOCK];
                        nxt_s.ctl[mbm_pkg::EC_SLEEP]  = dreq.wdata[mbm_pkg::EC_SLEEP];
                        nxt_s.ctl[5:4] = dreq.wdata[5:4];
                        nxt_s.ctl[mbm_pkg::EC_ARM] = dreq.wdata[mbm_pkg::EC_ARM];
                        if (dreq.wdata[mbm_pkg::EC_ARM] && !cur_ff.ctl[mbm_pkg::EC_ARM]) begin
                            nxt_s.lmask    = 8'h00;
                            nxt_s.row_held = 1'b0;
                        end
                        // go needs unlock and arm already set
                        if (dreq.wdata[mbm_pkg::EC_GO] && cur_ff.ctl[mbm_pkg::EC_UNLOCK]
                            && cur_ff.ctl[mbm_pkg::EC_ARM] && cur_ff.row_held) begin
                            nxt_s.ctl[mbm_pkg::EC_GO]   = 1'b1;
                            nxt_s.ctl[mbm_pkg::EC_BUSY] = 1'b1;
                            nxt_s.st  = mbm_pkg::MBM_ROW;
                            nxt_s.cnt = CW'(WRITE_CYC - 1);
                        end
                    end
                end
                default: ;
            endcase
        end
        // eeprom writes: latch in row mode, else start a byte write
        if (ee_wr) begin
            if (cur_ff.ctl[mbm_pkg::EC_ARM]) begin
                nxt_s.lat[dreq.addr[2:0]]   = dreq.wdata;
                nxt_s.lmask[dreq.addr[2:0]] = 1'b1;
                if (!cur_ff.row_held) begin
                    nxt_s.row_held = 1'b1;
                    nxt_s.row_sel  = ee_idx[6:3];
                end
            end else begin
                nxt_s.byte_addr = ee_idx;
                nxt_s.byte_data = dreq.wdata;
                nxt_s.ctl[mbm_pkg::EC_BUSY] = 1'b1;
                nxt_s.st  = mbm_pkg::MBM_BYTE;
                nxt_s.cnt = CW'(WRITE_CYC - 1);
            end
        end
        // programming timer
        if (cur_ff.st != mbm_pkg::MBM_IDLE) begin
            if (cur_ff.cnt == CW'(0)) begin
                nxt_s.st = mbm_pkg::MBM_IDLE;
                nxt_s.ctl[mbm_pkg::EC_BUSY] = 1'b0;
                if (cur_ff.st == mbm_pkg::MBM_ROW) begin
                    nxt_s.ctl[mbm_pkg::EC_GO]  = 1'b0;
                    nxt_s.ctl[mbm_pkg::EC_ARM] = 1'b0;
                    nxt_s.row_held = 1'b0;
                end
            end else begin
                nxt_s.cnt = cur_ff.cnt - CW'(1);
            end
        end
    end

    // =========================================================
    // registers; page/window/bank have no reset value
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur_ff.ctl      <= mbm_pkg::EECTL_RST;
            cur_ff.st       <= mbm_pkg::MBM_IDLE;
            cur_ff.cnt      <= '0;
            cur_ff.row_held <= 1'b0;
            cur_ff.page_ok  <= 1'b0;
            cur_ff.lmask    <= 8'h00;
            cur_ff.rd       <= 8'h00;
            cur_ff.rd_rom   <= 1'b0;
            cur_ff.fetch    <= '0;
            cur_ff.daddr    <= '0;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    // arrays: ram and eeprom cells
    always_ff @(posedge mclk) begin
        if (dreq.valid && dreq.write && in_fix) fix_ram[dreq.addr[5:0]] <= dreq.wdata;
        if (dreq.valid && dreq.write && bank_ram) ban_ram[bank_idx] <= dreq.wdata;
        if (cur_ff.st == mbm_pkg::MBM_BYTE && cur_ff.cnt == CW'(0))
            eeprom[cur_ff.byte_addr] <= cur_ff.byte_data;
        if (row_fin) begin
            for (int b = 0; b < mbm_pkg::ROW_BYTES; b++) begin
                // unloaded bytes come out erased
                eeprom[{cur_ff.row_sel, 3'(b)}] <= cur_ff.lmask[b] ? cur_ff.lat[b]
                                                                   : mbm_pkg::ERASED_BYTE;
            end
        end
    end

    assign ram_rd    = in_fix ? fix_ram[dreq.addr[5:0]] : ban_ram[bank_idx];
    assign eeprom_rd = eeprom[ee_idx];

    assign rom_fetch_addr    = cur_ff.fetch;
    assign rom_data_addr     = cur_ff.daddr;
    assign rdata             = cur_ff.rd_rom ? rom_data : cur_ff.rd;
    assign eeprom_power_down = cur_ff.ctl[mbm_pkg::EC_SLEEP];

    // =========================================================
    // checks
    sequence s_byte_go;
        ee_wr && !cur_ff.ctl[mbm_pkg::EC_ARM];
    endsequence
    sequence s_ee_refused_rd;
        dreq.valid && !dreq.write && ee_hit && (busy || cur_ff.ctl[mbm_pkg::EC_SLEEP]);
    endsequence
    sequence s_ctl_free;
        dreq.valid && dreq.write && dreq.addr == mbm_pkg::ADR_EECTL && !busy;
    endsequence
    sequence s_ctl_held;
        dreq.valid && dreq.write && dreq.addr == mbm_pkg::ADR_EECTL && busy;
    endsequence
    AST_STATIC_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        pc[11] |=> rom_fetch_addr[12:11] == mbm_pkg::STATIC_PAGE)
        else $error("high fetch left static page");
    // page is unknown until first written, so the check waits for that
    AST_PAGED_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.page_ok && !pc[11]) |=> rom_fetch_addr[12:11] == $past(cur_ff.page))
        else $error("low fetch not on selected page");
    AST_ROM_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> rom_data_addr[5:0] == $past(dreq.addr[5:0]))
        else $error("rom window low bits wrong");
    AST_BUSY_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        s_byte_go |=> busy)
        else $error("busy not set on write");
    AST_LOCKED: assert property (@(posedge mclk) disable iff (!rst_n)
        (!busy && !cur_ff.ctl[mbm_pkg::EC_UNLOCK] && dreq.addr != mbm_pkg::ADR_EECTL)
        |=> !busy)
        else $error("busy set while locked");
    AST_GO_GUARD: assert property (@(posedge mclk) disable iff (!rst_n)
        (!cur_ff.ctl[mbm_pkg::EC_GO] && !(cur_ff.ctl[mbm_pkg::EC_UNLOCK]
          && cur_ff.ctl[mbm_pkg::EC_ARM])) |=> !cur_ff.ctl[mbm_pkg::EC_GO])
        else $error("go set without unlock and arm");
    AST_ROW_END: assert property (@(posedge mclk) disable iff (!rst_n)
        row_fin |=> !cur_ff.ctl[mbm_pkg::EC_GO] && !cur_ff.ctl[mbm_pkg::EC_ARM]
        && !busy)
        else $error("row end did not clear go and arm");
    AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(busy) |-> busy [*8])
        else $error("busy dropped early");
    AST_SLEEP_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctl_free |=> eeprom_power_down == $past(dreq.wdata[mbm_pkg::EC_SLEEP]))
        else $error("sleep output wrong");
    // control is frozen while a write runs, sleep included
    AST_CTL_FROZEN: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctl_held |=> $stable(eeprom_power_down))
        else $error("control changed while busy");
    AST_REFUSED_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ee_refused_rd |=> rdata == mbm_pkg::ERASED_BYTE)
        else $error("eeprom read not refused");
    AST_GO_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(cur_ff.ctl[mbm_pkg::EC_GO]) |-> busy)
        else $error("row go without busy");
    AST_BUSY_STATE: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |-> busy == (cur_ff.st != mbm_pkg::MBM_IDLE))
        else $error("busy flag and timer disagree");
    // no disable here: this one watches the reset itself
    AST_CTL_RESET: assert property (@(posedge mclk)
        !rst_n |=> cur_ff.ctl == mbm_pkg::EECTL_RST)
        else $error("control not cleared by reset");
endmodule : mbm_mapper

// >>> dv/mbm_rom_model.sv
// Purpose: program ROM partner answering data window reads
// Assumes: combinational read on a 13-bit address
// Notes:   byte pattern depends on every address bit
`timescale 1ns/1ps
module mbm_rom_model (
    input  wire logic [12:0] addr,
    output logic [7:0]       data
);
    // ==========================================================
    // read path
    // page bits folded in so a wrong window value shows up
    assign data = addr[7:0] ^ {3'h0, addr[12:8]};
endmodule : mbm_rom_model

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the memory bank mapper
// Assumes: core side driven 1ns after mclk rise, reads seen next cycle
// Notes:   short write time parameter keeps eeprom waits brief
`timescale 1ns/1ps
module tb_top;
    localparam int         WC = 20;
    localparam logic [7:0] BK [5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    logic                  mclk;
    logic                  rst_n;
    logic [11:0]           pc;
    mbm_pkg::mbm_dreq_t    dreq;
    logic [7:0]            rom_data;
    logic [12:0]           rom_fetch_addr;
    logic [12:0]           rom_data_addr;
    logic [7:0]            rdata;
    logic                  eeprom_power_down;
    logic [7:0]            rd_q;
    int                    n_mismatch;
    int                    compares;

    always #5 mclk = ~mclk;

    mbm_mapper #(.WRITE_CYC(WC)) i_mbm_mapper (
        .mclk(mclk), .rst_n(rst_n), .pc(pc), .dreq(dreq), .rom_data(rom_data),
        .rom_fetch_addr(rom_fetch_addr), .rom_data_addr(rom_data_addr),
        .rdata(rdata), .eeprom_power_down(eeprom_power_down));
    mbm_rom_model i_mbm_rom_model (.addr(rom_data_addr), .data(rom_data));

    // ==========================================================
    // helpers
    function automatic logic [7:0] rom_exp(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction : rom_exp

    task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // one access, released a cycle later so back-to-back calls never collide
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 dreq = {1'b1, w, a, d};
        @(posedge mclk);
        #1 dreq.valid = 1'b0;
        rd_q = rdata;
    endtask : acc

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        acc(1'b0, a, 8'h00);
        chk({5'h00, rd_q}, {5'h00, exp}, msg);
    endtask : rdchk

    task automatic chk_pd(input logic exp);
        chk({12'h000, eeprom_power_down}, {12'h000, exp}, "power down");
    endtask : chk_pd

    // bounded poll: a stuck busy flag ends in a mismatch, not a hang
    task automatic ee_wait;
        int n;
        n = 0;
        do begin
            acc(1'b0, mbm_pkg::ADR_EECTL, 8'h00);
            n++;
        end while (rd_q[mbm_pkg::EC_BUSY] !== 1'b0 && n < 4 * WC);
        chk({12'h000, rd_q[mbm_pkg::EC_BUSY]}, 13'h0000, "busy stuck");
    endtask : ee_wait

    // ==========================================================
    // scenarios
    task automatic t_fetch;
        for (int p = 0; p < 4; p++) begin
            acc(1'b1, mbm_pkg::ADR_PAGE, 8'hFC | p[7:0]);
            pc = 12'h2A5;
            @(posedge mclk);
            #1 chk(rom_fetch_addr, {p[1:0], 11'h2A5}, "paged fetch");
            pc = 12'hFF3;
            @(posedge mclk);
            #1 chk(rom_fetch_addr, {2'b01, 11'h7F3}, "static fetch");
        end
    endtask : t_fetch

    task automatic t_window;
        acc(1'b1, mbm_pkg::ADR_DWIN, 8'hDA);
        rdchk(8'h40, rom_exp({7'h5A, 6'h00}), "window low");
        chk(rom_data_addr, {7'h5A, 6'h00}, "window addr");
        rdchk(8'h7F, rom_exp({7'h5A, 6'h3F}), "window high");
    endtask : t_window

    task automatic t_banks;
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, mbm_pkg::ADR_BANK, BK[i]);
            acc(1'b1, 8'h05, BK[i] ^ 8'h5A);
            acc(1'b1, 8'h25, BK[i] ^ 8'hA5);
        end
        acc(1'b1, 8'hBF, 8'h3C);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, mbm_pkg::ADR_BANK, BK[i]);
            rdchk(8'h05, BK[i] ^ 8'h5A, "bank data");
            rdchk(8'h25, BK[i] ^ 8'hA5, "bank upper half");
            rdchk(8'hBF, 8'h3C, "fixed ram");
        end
    endtask : t_banks

    task automatic t_byte;
        acc(1'b1, mbm_pkg::ADR_BANK, mbm_pkg::BANK_EE0);
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h01);
        acc(1'b1, 8'h03, 8'h5C);
        rdchk(mbm_pkg::ADR_EECTL, 8'h02, "busy set");
        rdchk(8'h03, mbm_pkg::ERASED_BYTE, "read while busy");
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h40);
        ee_wait;
        chk_pd(1'b0);
        rdchk(8'h03, 8'h5C, "byte written");
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h00);
        acc(1'b1, 8'h03, 8'h22);
        rdchk(mbm_pkg::ADR_EECTL, 8'h00, "locked busy");
        rdchk(8'h03, 8'h5C, "locked data");
    endtask : t_byte

    task automatic t_row;
        acc(1'b1, mbm_pkg::ADR_BANK, mbm_pkg::BANK_EE1);
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h05);
        for (int k = 0; k < 3; k++) acc(1'b1, 8'h10 | k[7:0], 8'hA0 | k[7:0]);
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h0D);
        rdchk(mbm_pkg::ADR_EECTL, 8'h02, "row busy");
        ee_wait;
        for (int k = 0; k < 3; k++) rdchk(8'h10 | k[7:0], 8'hA0 | k[7:0], "row");
        rdchk(8'h13, mbm_pkg::ERASED_BYTE, "unloaded byte");
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h09);
        rdchk(mbm_pkg::ADR_EECTL, 8'h00, "go without arm");
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h05);
        acc(1'b1, 8'h14, 8'h99);
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h00);
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h0D);
        rdchk(mbm_pkg::ADR_EECTL, 8'h00, "go with new arm");
        rdchk(8'h14, mbm_pkg::ERASED_BYTE, "unarm keeps");
    endtask : t_row

    task automatic t_sleep;
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h40);
        rdchk(8'h10, mbm_pkg::ERASED_BYTE, "asleep read");
        chk_pd(1'b1);
        acc(1'b1, mbm_pkg::ADR_EECTL, 8'h00);
        rdchk(8'h10, 8'hA0, "awake read");
        chk_pd(1'b0);
    endtask : t_sleep

    // ==========================================================
    // verdict
    task automatic print_verdict;
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        pc = 12'h000;
        dreq = '0;
        n_mismatch = 0;
        compares = 0;
        repeat (4) @(posedge mclk);
        #1 rst_n = 1'b1;
        rdchk(mbm_pkg::ADR_EECTL, mbm_pkg::EECTL_RST, "ctl reset");
        chk_pd(1'b0);
        t_fetch;
        t_window;
        t_banks;
        t_byte;
        t_row;
        t_sleep;
        print_verdict;
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        print_verdict;
    end
endmodule : tb_top
